// ===== logic/hssi_bus_if.sv
`timescale 1ns/1ps
interface hssi_bus_if;
  logic       scl_m_out;
  logic       scl_m_oe;
  logic       sda_m_out;
  logic       sda_m_oe;
  logic       sda_s_out;
  logic       sda_s_oe;
  logic       alert_s_out;
  logic       alert_s_oe;
  logic [1:0] addr_select_pin_a;
  logic [1:0] addr_select_pin_b;
  logic [1:0] addr_select_pin_c;
  logic       scl;
  logic       sda;
  logic       alert_n;

  // Pulled-up open-drain wires
  assign scl     = scl_m_oe ? scl_m_out : 1'b1;
  assign sda     = (sda_m_oe ? sda_m_out : 1'b1) & (sda_s_oe ? sda_s_out : 1'b1);
  assign alert_n = alert_s_oe ? alert_s_out : 1'b1;

  modport dev (input scl, input sda, input addr_select_pin_a, input addr_select_pin_b,
               input addr_select_pin_c, output sda_s_out, output sda_s_oe,
               output alert_s_out, output alert_s_oe);
  modport host (input scl, input sda, input alert_n, output scl_m_out, output scl_m_oe,
                output sda_m_out, output sda_m_oe);
endinterface

// ===== logic/hssi_device.sv
// Overview of operation
// - Three tri-level pins give 27 addresses
// - Pin combination maps to tabulated address byte
// - Mass write address C6 accepted while Control2 bit 4 set
// - Control2 bit 4 low disables mass write
// - Alert response: ack, send address, release
// - Transmitter releases SDA during acknowledge pulse
// - Receiving device holds SDA low on ack
// - Master may stop after missing ack
// - Master acks reads, nacks last, stops
// - Address, command byte; low bits load pointer
// - One data byte acked, stored, then stop
// - Second write data byte acked, discarded
// - Repeated start, read address, returns pointed register
// - Acked first read byte: resend same register
// - Alert low when enabled fault bit set
// - Direct addressing also releases alert
// - Re-alert only on new or re-set fault
// - Line low over 25 ms resets interface
// - Unsupported command codes not acknowledged
`timescale 1ns/1ps
module hssi_device #(
  parameter int unsigned TIMEOUT_CYCLES = hssi_pkg::TIMEOUT_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  hssi_bus_if.dev         bus,
  input  wire logic [7:0] status_ch1,
  input  wire logic [7:0] status_ch2,
  input  wire logic [7:0] fault_set_ch1,
  input  wire logic [7:0] fault_set_ch2,
  output logic      [7:0] control_ch1,
  output logic      [7:0] control_ch2,
  output logic      [7:0] fault_log_ch1,
  output logic      [7:0] fault_log_ch2,
  output logic      [6:0] own_address,
  output logic            address_valid
);
  localparam logic [hssi_pkg::TO_W-1:0] TO_LIMIT = hssi_pkg::TO_W'(TIMEOUT_CYCLES);

  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK, D_IGNORE} hssi_dst_e;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA1, PH_DATAN} hssi_ph_e;

  typedef struct packed {
    logic [1:0]                scl_s;
    logic [1:0]                sda_s;
    logic                      scl_q;
    logic                      sda_q;
    logic [5:0]                pins_m;
    logic [5:0]                pins_s;
    logic [1:0]                latch_cnt;
    logic                      addr_ok;
    logic [6:0]                own;
    hssi_dst_e                 st;
    hssi_ph_e                  ph;
    logic [3:0]                cnt;
    logic [7:0]                shreg;
    logic [7:0]                tx_byte;
    logic                      rd;
    logic                      ara;
    logic                      ack_ok;
    logic [2:0]                ptr;
    logic [7:0][7:0]           regs;
    logic [15:0]               snap;
    logic                      alert_drv;
    logic                      sda_drv;
    logic [hssi_pkg::TO_W-1:0] to_cnt;
  } hssi_dev_s;

  hssi_dev_s   s;
  hssi_dev_s   next_s;
  logic [15:0] cur;
  logic        rel;
  logic        ack;
  logic        load_tx;
  logic [7:0]  txb;
  logic [7:0]  pin_addr;
  logic        scl;
  logic        sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        direct;

  function automatic logic [4:0] lvl(input logic [1:0] p);
    return {3'h0, ((p == hssi_pkg::PIN_LOW) || (p == hssi_pkg::PIN_HIGH)) ? p
                                                                         : hssi_pkg::PIN_OPEN};
  endfunction

  function automatic logic [7:0] addr_of(input logic [5:0] p);
    logic [4:0] idx;
    idx = lvl(p[5:4]) * 5'h09 + lvl(p[3:2]) * 5'h03 + lvl(p[1:0]);
    return hssi_pkg::ADDR_TABLE[idx];
  endfunction

  assign pin_addr = addr_of(s.pins_s);
  assign scl      = s.scl_s[1];
  assign sda      = s.sda_s[1];
  assign scl_rise = scl & ~s.scl_q;
  assign scl_fall = ~scl & s.scl_q;

  always_comb begin
    next_s  = s;
    rel     = 1'b0;
    ack     = 1'b0;
    load_tx = 1'b0;
    txb     = s.regs[s.ptr];
    direct  = s.addr_ok && (s.shreg[7:1] == s.own);
    cur     = {s.regs[hssi_pkg::REG_FAULT2] & s.regs[hssi_pkg::REG_ALERT2],
               s.regs[hssi_pkg::REG_FAULT1] & s.regs[hssi_pkg::REG_ALERT1]};
    next_s.scl_s  = {s.scl_s[0], bus.scl};
    next_s.sda_s  = {s.sda_s[0], bus.sda};
    next_s.scl_q  = scl;
    next_s.sda_q  = sda;
    next_s.pins_m = {bus.addr_select_pin_c, bus.addr_select_pin_b, bus.addr_select_pin_a};
    next_s.pins_s = s.pins_m;
    if (!s.addr_ok) begin
      if (s.latch_cnt == hssi_pkg::LATCH_DELAY) begin
        next_s.addr_ok = 1'b1;
        next_s.own     = pin_addr[7:1];
      end else begin
        next_s.latch_cnt = s.latch_cnt + 2'h1;
      end
    end
    next_s.regs[hssi_pkg::REG_STAT1] = status_ch1;
    next_s.regs[hssi_pkg::REG_STAT2] = status_ch2;

    case (s.st)
      D_RX: begin
        if (scl_rise) begin
          next_s.shreg = {s.shreg[6:0], sda};
          next_s.cnt   = s.cnt + 4'h1;
        end else if (scl_fall && (s.cnt == 4'h8)) begin
          case (s.ph)
            PH_ADDR: begin
              next_s.rd  = s.shreg[0];
              next_s.ara = s.alert_drv && (s.shreg == hssi_pkg::ALERT_RESP_ADDR);
              ack = direct || next_s.ara ||
                    ((s.shreg == hssi_pkg::MASS_WRITE_ADDR) &&
                     s.regs[hssi_pkg::REG_CTRL2][hssi_pkg::MASS_EN_BIT]);
              rel = direct;
            end
            PH_CMD: begin
              ack = (s.shreg[7:3] == hssi_pkg::CMD_BASE);
              if (ack) begin
                next_s.ptr = s.shreg[2:0];
              end
            end
            PH_DATA1: begin
              ack = 1'b1;
              if ((s.ptr != hssi_pkg::REG_STAT1) && (s.ptr != hssi_pkg::REG_STAT2)) begin
                next_s.regs[s.ptr] = s.shreg;
              end
            end
            default: ack = 1'b1;
          endcase
          next_s.sda_drv = ack;
          next_s.st      = ack ? D_ACK : D_IGNORE;
        end
      end
      D_ACK: begin
        if (scl_fall) begin
          next_s.sda_drv = 1'b0;
          next_s.cnt     = 4'h0;
          next_s.st      = D_RX;
          case (s.ph)
            PH_ADDR: begin
              if (s.rd) begin
                load_tx = 1'b1;
                txb     = s.ara ? {s.own, 1'b0} : s.regs[s.ptr];
              end else begin
                next_s.ph = PH_CMD;
              end
            end
            PH_CMD:  next_s.ph = PH_DATA1;
            default: next_s.ph = PH_DATAN;
          endcase
        end
      end
      D_TX: begin
        if (scl_fall) begin
          if (s.cnt == 4'h8) begin
            next_s.sda_drv = 1'b0;
            next_s.st      = D_TXACK;
            rel            = s.ara;
          end else begin
            next_s.sda_drv = ~s.shreg[7];
            next_s.shreg   = {s.shreg[6:0], 1'b0};
            next_s.cnt     = s.cnt + 4'h1;
          end
        end
      end
      D_TXACK: begin
        if (scl_rise) begin
          next_s.ack_ok = ~sda;
        end else if (scl_fall) begin
          load_tx   = s.ack_ok;
          txb       = s.ara ? s.tx_byte : s.regs[s.ptr];
          next_s.st = D_IGNORE;
        end
      end
      default: ;
    endcase

    if (load_tx) begin
      next_s.tx_byte = txb;
      next_s.shreg   = {txb[6:0], 1'b0};
      next_s.sda_drv = ~txb[7];
      next_s.cnt     = 4'h1;
      next_s.st      = D_TX;
    end

    // Start and stop override any bit-level state
    if (scl && s.scl_q && s.sda_q && !sda) begin
      next_s.st      = D_RX;
      next_s.ph      = PH_ADDR;
      next_s.cnt     = 4'h0;
      next_s.sda_drv = 1'b0;
    end else if (scl && s.scl_q && !s.sda_q && sda) begin
      next_s.st      = D_IDLE;
      next_s.sda_drv = 1'b0;
    end

    if (!scl || !sda) begin
      if (s.to_cnt != TO_LIMIT) begin
        next_s.to_cnt = s.to_cnt + 1'b1;
      end
    end else begin
      next_s.to_cnt = '0;
    end
    if (s.to_cnt == TO_LIMIT) begin
      next_s.st      = D_IDLE;
      next_s.sda_drv = 1'b0;
    end

    // Fault events win over a same-cycle write
    next_s.regs[hssi_pkg::REG_FAULT1] = next_s.regs[hssi_pkg::REG_FAULT1] | fault_set_ch1;
    next_s.regs[hssi_pkg::REG_FAULT2] = next_s.regs[hssi_pkg::REG_FAULT2] | fault_set_ch2;

    next_s.snap      = rel ? cur : (s.snap & cur);
    next_s.alert_drv = |(cur & ~next_s.snap);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s                          <= '0;
      s.scl_s                    <= 2'h3;
      s.sda_s                    <= 2'h3;
      s.scl_q                    <= 1'b1;
      s.sda_q                    <= 1'b1;
      s.regs[hssi_pkg::REG_CTRL1] <= hssi_pkg::CTRL1_RST;
      s.regs[hssi_pkg::REG_CTRL2] <= hssi_pkg::CTRL2_RST;
    end else begin
      s <= next_s;
    end
  end

  assign bus.sda_s_out   = 1'b0;
  assign bus.sda_s_oe    = s.sda_drv;
  assign bus.alert_s_out = 1'b0;
  assign bus.alert_s_oe  = s.alert_drv;
  assign control_ch1     = s.regs[hssi_pkg::REG_CTRL1];
  assign control_ch2     = s.regs[hssi_pkg::REG_CTRL2];
  assign fault_log_ch1   = s.regs[hssi_pkg::REG_FAULT1];
  assign fault_log_ch2   = s.regs[hssi_pkg::REG_FAULT2];
  assign own_address     = s.own;
  assign address_valid   = s.addr_ok;
endmodule // hssi_device

// ===== logic/hssi_master.sv
`timescale 1ns/1ps
module hssi_master (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  hssi_bus_if.host               bus,
  input  wire logic              cmd_valid,
  input  hssi_pkg::hssi_op_e     cmd_op,
  input  wire logic        [6:0] cmd_addr,
  input  wire logic        [7:0] cmd_code,
  input  wire logic       [15:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   done,
  output logic                   nack,
  output logic            [15:0] rdata,
  output logic                   alert_seen
);
  localparam logic [7:0] QMAX = 8'(hssi_pkg::QTR_CYCLES - 1);

  typedef enum logic [1:0] {M_IDLE, M_RUN, M_STOP} hssi_mst_e;
  typedef enum logic [1:0] {K_START, K_TX, K_RX, K_END} hssi_kind_e;
  typedef struct packed {
    hssi_kind_e kind;
    logic       last;
    logic [7:0] data;
  } hssi_item_s;

  typedef struct packed {
    hssi_mst_e          st;
    hssi_pkg::hssi_op_e op;
    logic [6:0]         addr;
    logic [7:0]         code;
    logic [15:0]        wdata;
    logic [2:0]         idx;
    logic [1:0]         q;
    logic [7:0]         qcnt;
    logic [3:0]         bitn;
    logic [7:0]         shreg;
    logic [15:0]        rx;
    logic [1:0]         sda_s;
    logic [1:0]         alert_s;
    logic               scl_drv;
    logic               sda_drv;
    logic               nack;
    logic               done;
    logic               ready;
  } hssi_mst_s;

  hssi_mst_s  s;
  hssi_mst_s  next_s;
  hssi_item_s it;
  logic [7:0] byte_now;
  logic       sda;
  logic       tick;

  function automatic hssi_item_s item(input hssi_mst_s m);
    logic wr;
    logic ar;
    wr = (m.op == hssi_pkg::OP_WR_BYTE) || (m.op == hssi_pkg::OP_WR_WORD);
    ar = (m.op == hssi_pkg::OP_ALERT_RSP);
    item = '{K_END, 1'b0, 8'h00};
    case (m.idx)
      3'h0: item = '{K_START, 1'b0, 8'h00};
      3'h1: item = '{K_TX, 1'b0, ar ? hssi_pkg::ALERT_RESP_ADDR : {m.addr, 1'b0}};
      3'h2: item = ar ? hssi_item_s'{K_RX, 1'b1, 8'h00} : hssi_item_s'{K_TX, 1'b0, m.code};
      3'h3: if (wr) item = '{K_TX, 1'b0, m.wdata[7:0]};
            else if (!ar) item = '{K_START, 1'b0, 8'h00};
      3'h4: if (m.op == hssi_pkg::OP_WR_WORD) item = '{K_TX, 1'b0, m.wdata[15:8]};
            else if (!wr && !ar) item = '{K_TX, 1'b0, {m.addr, 1'b1}};
      3'h5: if (!wr && !ar) item = '{K_RX, m.op == hssi_pkg::OP_RD_BYTE, 8'h00};
      3'h6: if (m.op == hssi_pkg::OP_RD_WORD) item = '{K_RX, 1'b1, 8'h00};
      default: ;
    endcase
  endfunction

  assign sda  = s.sda_s[1];
  assign tick = (s.qcnt == QMAX);
  assign it   = item(s);

  always_comb begin
    next_s         = s;
    byte_now       = (s.bitn == 4'h0) ? it.data : s.shreg;
    next_s.done    = 1'b0;
    next_s.sda_s   = {s.sda_s[0], bus.sda};
    next_s.alert_s = {s.alert_s[0], ~bus.alert_n};
    next_s.qcnt    = tick ? 8'h00 : s.qcnt + 8'h01;
    case (s.st)
      M_IDLE: begin
        next_s.ready = 1'b1;
        if (cmd_valid) begin
          next_s = '{st: M_RUN, op: cmd_op, addr: cmd_addr, code: cmd_code,
                     wdata: cmd_wdata, sda_s: next_s.sda_s, alert_s: next_s.alert_s,
                     default: '0};
        end
      end
      M_RUN: begin
        if (tick) begin
          next_s.q = s.q + 2'h1;
          case (it.kind)
            K_START: begin
              case (s.q)
                2'h0: next_s.sda_drv = 1'b0;
                2'h1: next_s.scl_drv = 1'b0;
                2'h2: next_s.sda_drv = 1'b1;
                default: begin
                  next_s.scl_drv = 1'b1;
                  next_s.idx     = s.idx + 3'h1;
                end
              endcase
            end
            K_TX, K_RX: begin
              case (s.q)
                2'h0: begin
                  if (s.bitn == 4'h8) begin
                    next_s.sda_drv = (it.kind == K_RX) && !it.last;
                  end else if (it.kind == K_TX) begin
                    next_s.sda_drv = ~byte_now[7];
                    next_s.shreg   = {byte_now[6:0], 1'b0};
                  end else begin
                    next_s.sda_drv = 1'b0;
                  end
                end
                2'h1: next_s.scl_drv = 1'b0;
                2'h2: begin
                  if ((it.kind == K_TX) && (s.bitn == 4'h8) && sda) begin
                    next_s.nack = 1'b1;
                  end else if ((it.kind == K_RX) && (s.bitn != 4'h8)) begin
                    next_s.rx = {s.rx[14:0], sda};
                  end
                end
                default: begin
                  next_s.scl_drv = 1'b1;
                  next_s.bitn    = s.bitn + 4'h1;
                  if (s.bitn == 4'h8) begin
                    next_s.bitn = 4'h0;
                    next_s.idx  = s.idx + 3'h1;
                    if (s.nack) begin
                      next_s.st = M_STOP;
                    end
                  end
                end
              endcase
            end
            default: begin
              next_s.st = M_STOP;
              next_s.q  = 2'h0;
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          next_s.q = s.q + 2'h1;
          case (s.q)
            2'h0: next_s.sda_drv = 1'b1;
            2'h1: next_s.scl_drv = 1'b0;
            2'h2: next_s.sda_drv = 1'b0;
            default: begin
              next_s.st    = M_IDLE;
              next_s.done  = 1'b1;
              next_s.ready = 1'b1;
            end
          endcase
        end
      end
      default: next_s.st = M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s       <= '0;
      s.sda_s <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign bus.scl_m_out = 1'b0;
  assign bus.scl_m_oe  = s.scl_drv;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe  = s.sda_drv;
  assign cmd_ready     = s.ready;
  assign done          = s.done;
  assign nack          = s.nack;
  assign rdata         = s.rx;
  assign alert_seen    = s.alert_s[1];
endmodule // hssi_master

// ===== logic/hssi_pkg.sv
package hssi_pkg;
  localparam int CLK_HZ         = 50000000;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TIMEOUT_MS     = 25;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TO_W           = 21;
  localparam int SCL_PERIOD_NS  = 2500;
  localparam int QTR_CYCLES     = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_OPEN = 2'h2;
  localparam logic [1:0] LATCH_DELAY = 2'h3;

  localparam logic [7:0] MASS_WRITE_ADDR = 8'hC6;
  localparam logic [7:0] ALERT_RESP_ADDR = 8'h19;
  localparam logic [4:0] CMD_BASE        = 5'h1A;

  localparam logic [2:0] REG_CTRL1  = 3'h0;
  localparam logic [2:0] REG_ALERT1 = 3'h1;
  localparam logic [2:0] REG_STAT1  = 3'h2;
  localparam logic [2:0] REG_FAULT1 = 3'h3;
  localparam logic [2:0] REG_CTRL2  = 3'h4;
  localparam logic [2:0] REG_ALERT2 = 3'h5;
  localparam logic [2:0] REG_STAT2  = 3'h6;
  localparam logic [2:0] REG_FAULT2 = 3'h7;
  localparam logic [7:0] CTRL1_RST  = 8'h07;
  localparam logic [7:0] CTRL2_RST  = 8'h17;
  localparam int         MASS_EN_BIT = 4;

  // Index is pin_c*9 + pin_b*3 + pin_a, level codes low 0, high 1, open 2
  localparam logic [7:0] ADDR_TABLE [27] = '{
    8'h98, 8'h9E, 8'h9C, 8'hE8, 8'h9A, 8'h8A, 8'h88, 8'h8E, 8'h8C,
    8'hD8, 8'hDE, 8'hDC, 8'hEC, 8'hDA, 8'hCA, 8'hC8, 8'hCE, 8'hCC,
    8'hB8, 8'hBE, 8'hBC, 8'hEA, 8'hBA, 8'hAA, 8'hA8, 8'hAE, 8'hAC};

  typedef enum logic [2:0] {
    OP_WR_BYTE, OP_WR_WORD, OP_RD_BYTE, OP_RD_WORD, OP_ALERT_RSP
  } hssi_op_e;
endpackage

// ===== sim/hssi_props.sv
`timescale 1ns/1ps
module hssi_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic alert_s_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence

  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence

  sda_hold_ack_a: assert property (sda_s_oe && $rose(scl) |-> sda_s_oe [*8])
    else $error("Device let go of SDA early in the SCL high phase");
  no_contention_a: assert property (scl |-> !(sda_m_oe && sda_s_oe))
    else $error("Both ends drive SDA while SCL is high");
  edge_change_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("Device changed SDA while SCL is high");
  dev_latency_a: assert property ($changed(sda_s_oe) |->
    ($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
    else $error("Device SDA change not tied to an SCL fall");
  start_idle_a: assert property (start_s |-> !sda_s_oe)
    else $error("Device drives SDA at a start");
  stop_release_a: assert property (stop_s |=> !sda_s_oe [*8])
    else $error("Device drives SDA after a stop");
  data_stable_a: assert property ($rose(scl) |-> $stable(sda) [*8])
    else $error("SDA moved early in the SCL high phase");
  alert_release_a: assert property ($fell(alert_s_oe) |-> !scl)
    else $error("Alert released outside an SCL low phase");
endmodule // hssi_props

// ===== sim/hssi_tb_top.sv
`timescale 1ns/1ps
`define HSSI_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; $display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module hssi_tb_top;
  localparam int         TO_SIM     = 8000;
  localparam int         QB         = 10;
  localparam logic [7:0] DEV_B_BYTE = 8'h98;
  logic               core_clk;
  logic               resetn;
  logic [7:0]         fault_set;
  logic [7:0]         status_in;
  logic               cmd_valid;
  hssi_pkg::hssi_op_e cmd_op;
  logic [6:0]         cmd_addr;
  logic [7:0]         cmd_code;
  logic [15:0]        cmd_wdata;
  logic               cmd_ready;
  logic               done;
  logic               nack;
  logic [15:0]        rdata;
  logic               alert_seen;
  logic [7:0]         control_ch1;
  logic [7:0]         control_ch2;
  logic [7:0]         fault_log_ch1;
  logic [6:0]         own_address;
  logic               address_valid;
  int                 fail_count = 0;
  int                 total_checks = 0;
  int                 cycles = 0;

  hssi_bus_if bus ();
  hssi_bus_if bus2 ();

  hssi_device #(.TIMEOUT_CYCLES(TO_SIM)) u_hssi_device (
    .core_clk(core_clk), .resetn(resetn), .bus(bus.dev), .status_ch1(status_in),
    .status_ch2(8'h00), .fault_set_ch1(fault_set), .fault_set_ch2(8'h00),
    .control_ch1(control_ch1), .control_ch2(control_ch2), .fault_log_ch1(fault_log_ch1),
    .fault_log_ch2(), .own_address(own_address), .address_valid(address_valid));
  hssi_device #(.TIMEOUT_CYCLES(TO_SIM)) u_hssi_device_b (
    .core_clk(core_clk), .resetn(resetn), .bus(bus2.dev), .status_ch1(8'h00),
    .status_ch2(8'h00), .fault_set_ch1(fault_set), .fault_set_ch2(8'h00),
    .control_ch1(), .control_ch2(), .fault_log_ch1(), .fault_log_ch2(),
    .own_address(), .address_valid());
  hssi_master u_hssi_master (
    .core_clk(core_clk), .resetn(resetn), .bus(bus.host), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .done(done), .nack(nack), .rdata(rdata), .alert_seen(alert_seen));
  hssi_props u_hssi_props (
    .core_clk(core_clk), .resetn(resetn), .scl(bus.scl), .sda(bus.sda),
    .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .alert_s_oe(bus.alert_s_oe));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic run_cmd(input hssi_pkg::hssi_op_e op, input logic [6:0] addr,
                         input logic [7:0] code, input logic [15:0] wdata);
    int guard;
    guard = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && guard < 100) begin
      @(negedge core_clk);
      guard++;
    end
    @(posedge core_clk);
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_code <= code;
    cmd_wdata <= wdata;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    guard = 0;
    while (done !== 1'b1 && guard < 10000) begin
      @(negedge core_clk);
      guard++;
    end
    `HSSI_CHK(guard < 10000, 1'b1)
    @(posedge core_clk);
  endtask

  task automatic test_addresses();
    for (int i = 0; i < 28; i++) begin
      bus.addr_select_pin_a <= (i == 27) ? 2'h1 : 2'(i % 3);
      bus.addr_select_pin_b <= (i == 27) ? 2'h2 : 2'((i / 3) % 3);
      bus.addr_select_pin_c <= (i == 27) ? 2'h0 : 2'(i / 9);
      resetn <= 1'b0;
      wait_clk(2);
      resetn <= 1'b1;
      wait_clk(12);
      @(negedge core_clk);
      if (i < 27) begin
        `HSSI_CHK(own_address, hssi_pkg::ADDR_TABLE[i][7:1])
      end
      `HSSI_CHK(address_valid, 1'b1)
    end
    `HSSI_CHK(own_address, 7'h47)
    `HSSI_CHK({control_ch1, control_ch2}, 16'h0717)
    @(posedge core_clk);
  endtask

  task automatic test_write_read();
    run_cmd(hssi_pkg::OP_WR_WORD, 7'h47, 8'hD0, 16'hC35A);
    `HSSI_CHK(nack, 1'b0)
    `HSSI_CHK(control_ch1, 8'h5A)
    run_cmd(hssi_pkg::OP_RD_WORD, 7'h47, 8'hD0, 16'h0000);
    `HSSI_CHK(rdata, 16'h5A5A)
    run_cmd(hssi_pkg::OP_RD_BYTE, 7'h47, 8'hD2, 16'h0000);
    `HSSI_CHK(rdata, 16'h00A5)
    run_cmd(hssi_pkg::OP_WR_BYTE, 7'h10, 8'hD0, 16'h0011);
    `HSSI_CHK(nack, 1'b1)
  endtask

  task automatic test_mass_write();
    run_cmd(hssi_pkg::OP_WR_BYTE, 7'h63, 8'hD1, 16'h0021);
    `HSSI_CHK(nack, 1'b0)
    run_cmd(hssi_pkg::OP_WR_BYTE, 7'h47, 8'hD4, 16'h0007);
    `HSSI_CHK(control_ch2, 8'h07)
    run_cmd(hssi_pkg::OP_WR_BYTE, 7'h63, 8'hD1, 16'h0000);
    `HSSI_CHK(nack, 1'b1)
  endtask

  task automatic pulse_fault(input logic [7:0] bits);
    fault_set <= bits;
    @(posedge core_clk);
    fault_set <= 8'h00;
    wait_clk(6);
  endtask

  task automatic test_alert();
    pulse_fault(8'h01);
    `HSSI_CHK(alert_seen, 1'b1)
    run_cmd(hssi_pkg::OP_ALERT_RSP, 7'h0C, 8'h00, 16'h0000);
    `HSSI_CHK({nack, rdata[7:0]}, 9'h08E)
    pulse_fault(8'h01);
    `HSSI_CHK(alert_seen, 1'b0)
    pulse_fault(8'h20);
    `HSSI_CHK({alert_seen, fault_log_ch1}, 9'h121)
    run_cmd(hssi_pkg::OP_WR_BYTE, 7'h47, 8'hD8, 16'h0055);
    wait_clk(6);
    `HSSI_CHK({nack, alert_seen}, 2'b10)
    run_cmd(hssi_pkg::OP_WR_BYTE, 7'h47, 8'hD3, 16'h0000);
    pulse_fault(8'h01);
    `HSSI_CHK(alert_seen, 1'b1)
  endtask

  task automatic drive_bit_b(input logic b);
    bus2.sda_m_oe <= ~b;
    wait_clk(QB);
    bus2.scl_m_oe <= 1'b0;
    wait_clk(QB);
    bus2.scl_m_oe <= 1'b1;
    wait_clk(QB);
  endtask

  task automatic test_timeout();
    bus2.sda_m_oe <= 1'b1;
    wait_clk(QB);
    bus2.scl_m_oe <= 1'b1;
    wait_clk(QB);
    for (int i = 7; i >= 0; i--) begin
      drive_bit_b(DEV_B_BYTE[i]);
    end
    bus2.sda_m_oe <= 1'b0;
    wait_clk(QB);
    `HSSI_CHK(bus2.sda_s_oe, 1'b1)
    wait_clk(TO_SIM + 20);
    `HSSI_CHK(bus2.sda_s_oe, 1'b0)
    bus2.scl_m_oe <= 1'b0;
    wait_clk(QB);
  endtask

  initial begin
    resetn = 1'b0;
    fault_set = 8'h00;
    status_in = 8'hA5;
    cmd_valid = 1'b0;
    cmd_op = hssi_pkg::OP_WR_BYTE;
    cmd_addr = 7'h00;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    bus.addr_select_pin_a = 2'h1;
    bus.addr_select_pin_b = 2'h2;
    bus.addr_select_pin_c = 2'h0;
    bus2.addr_select_pin_a = 2'h0;
    bus2.addr_select_pin_b = 2'h0;
    bus2.addr_select_pin_c = 2'h0;
    bus2.scl_m_out = 1'b0;
    bus2.sda_m_out = 1'b0;
    bus2.scl_m_oe = 1'b0;
    bus2.sda_m_oe = 1'b0;
    wait_clk(2);
    resetn <= 1'b1;
    wait_clk(12);
    test_addresses();
    test_write_read();
    test_mass_write();
    test_alert();
    test_timeout();
    give_verdict();
  end
endmodule // hssi_tb_top
